// ### scic_ctrl.v
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "scic_map.vh"
module scic_ctrl (
  input wire sys_clk, // System clock, 100 MHz
  input wire rstn, // Synchronous reset, low active
  input wire clkEn, // Freezes all state when low
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size, word only
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output reg [31:0] hrdata, // AHB read data
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response
  input wire ceN, // Serial chip enable, low active
  input wire sck, // Serial clock from host
  input wire din, // Serial data in
  output reg dout, // Serial data out
  input wire caseSwitchIn, // Tamper switch input
  output reg irqN, // Interrupt, low active
  output reg cmdStart, // Engine launch pulse
  output reg [3:0] cmdCode, // Engine command code
  output wire [2:0] upDownSpacingSel, // Up-down start spacing
  output wire [3:0] launchDividerSel, // Launch divider
  output wire continuousTimingCtl, // Continuous timing control
  output wire continuousIrqCtl // Continuous interrupt control
);
  localparam PH_OP = 2'd0;
  localparam PH_DATA = 2'd1;
  localparam PH_EXEC = 2'd2;
  localparam PH_DEAD = 2'd3;

  wire ceNow;
  wire sckNow;
  wire dinNow;
  wire swNow;
  wire ceLvl;
  wire sckLvl;
  wire dinLvl;
  wire swLvl;
  reg [1:0] phase;
  reg [3:0] bitCnt;
  reg [7:0] opcode;
  reg [7:0] addr;
  reg [15:0] shIn;
  reg [15:0] shOut;
  reg isRd;
  reg busy;
  reg runMode;
  reg [7:0] status;
  reg [15:0] cfg [0:`SCIC_CFG_N-1];
  reg [15:0] res [0:`SCIC_RES_N-1];
  reg dpWrite;
  reg [7:0] dpAddr;
  integer i;

  // Helpers for opcode classes
  function isReadOp;
    input [7:0] a;
    begin
      isReadOp = (a >= `SCIC_RD_LO_A && a <= `SCIC_RD_HI_A) || (a >= `SCIC_RD_LO_B);
    end
  endfunction

  function isWriteOp;
    input [7:0] a;
    begin
      isWriteOp = (a >= `SCIC_WR_LO_A && a <= `SCIC_WR_HI_A) || (a >= `SCIC_WR_LO_B && a <= `SCIC_WR_HI_B);
    end
  endfunction

  function isExecOp;
    input [7:0] a;
    begin
      isExecOp = (a <= `SCIC_OP_HALT) || (a == `SCIC_OP_CAL);
    end
  endfunction

  // Config index from a read-side location
  function [4:0] cfgIdx;
    input [7:0] a;
    reg [7:0] t;
    begin
      t = (a <= `SCIC_RD_HI_A) ? a - `SCIC_RD_LO_A : a - `SCIC_RD_LO_B + 8'h04;
      cfgIdx = t[4:0];
    end
  endfunction

  // Chip enable idles high, so reset to high avoids a false frame start
  scic_sync #(
    .RST_VAL(1'b1)
  ) syncCe (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(ceN),
    .levelNow(ceNow),
    .levelQ(ceLvl)
  );

  // Serial clock idles low
  scic_sync #(
    .RST_VAL(1'b0)
  ) syncSck (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(sck),
    .levelNow(sckNow),
    .levelQ(sckLvl)
  );

  // Data input shares the clock's delay, so it is settled at each fall
  scic_sync #(
    .RST_VAL(1'b0)
  ) syncDin (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(din),
    .levelNow(dinNow),
    .levelQ(dinLvl)
  );

  // Tamper switch idles low
  scic_sync #(
    .RST_VAL(1'b0)
  ) syncSw (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(caseSwitchIn),
    .levelNow(swNow),
    .levelQ(swLvl)
  );

  wire ceFall = ceLvl & ~ceNow;
  wire ceRise = ~ceLvl & ceNow;
  wire sckFall = ~ceLvl & sckLvl & ~sckNow;
  wire sckRise = ~ceLvl & ~sckLvl & sckNow;
  wire swEvent = ~swLvl & swNow;

  // Opcode and data words as they complete, MSB first
  wire [7:0] opNow = {shIn[6:0], dinNow};
  wire [15:0] dataNow = {shIn[14:0], dinNow};
  wire opLast = sckFall & (phase == PH_OP) & (bitCnt == 4'd7);
  wire wordLast = sckFall & (phase == PH_DATA) & (bitCnt == 4'd15);
  wire [7:0] addrInc = addr + 8'h01;
  wire [7:0] rdAddr = (phase == PH_OP) ? opNow : addrInc;
  wire rdLoad = (opLast & isReadOp(opNow)) | (wordLast & isRd);
  wire readStatus = rdLoad & (rdAddr == `SCIC_STATUS_RD);

  // Read mux over the 16-bit register space
  reg [15:0] rdData;
  reg [7:0] resOff;
  always @* begin
    resOff = rdAddr - `SCIC_RES_LO;
    rdData = 16'h0000;
    if (rdAddr == `SCIC_STATUS_RD) begin
      rdData = {8'h00, status};
    end else if (rdAddr >= `SCIC_RES_LO) begin
      rdData = res[resOff[5:0]];
    end else if (isReadOp(rdAddr)) begin
      rdData = cfg[cfgIdx(rdAddr)];
    end
  end

  // AHB data-phase decode for engine reports
  wire ahbAddrPh = hsel & htrans[1] & hready;
  wire [5:0] done = (dpWrite && dpAddr == `SCIC_AHB_DONE) ? hwdata[5:0] : 6'h00;
  wire resWrite = dpWrite && (dpAddr == `SCIC_AHB_RESULT) && (hwdata[7:0] >= `SCIC_RES_LO);
  wire [7:0] resWrOff = hwdata[7:0] - `SCIC_RES_LO;
  // Code widened back to a full opcode so the map constants apply as they are
  wire [7:0] cmdOp = {4'h0, cmdCode};
  wire diffCmd = (cmdOp == `SCIC_OP_DIFF) | (cmdOp == `SCIC_OP_AUTO_FT) | (cmdOp == `SCIC_OP_AUTO_F);

  // Events into status; flags come from engine completions and tamper
  wire [7:0] evt = {2'b00, done[`SCIC_ST_TMO], swEvent, done[`SCIC_ST_CAL], done[`SCIC_ST_HALT],
    done[`SCIC_ST_TEMP], done[`SCIC_ST_FLIGHT]};
  wire [7:0] stClr = readStatus ? status : 8'h00;

  // Execution decode at chip-enable release
  wire execGo = ceRise & (phase == PH_EXEC) & isExecOp(opcode);
  wire [3:0] divSel = cfg[`SCIC_CFG_TOF1][`SCIC_DIV_HI:`SCIC_DIV_LO];
  wire [3:0] opLow = opcode[3:0];
  wire launchOp = (opcode == `SCIC_OP_UP) | (opcode == `SCIC_OP_DOWN) | (opcode == `SCIC_OP_DIFF)
    | (opcode == `SCIC_OP_TEMP) | (opcode == `SCIC_OP_CAL)
    | ((opcode == `SCIC_OP_FILTER) & (divSel != `SCIC_DIV_REFUSED))
    | ((opcode == `SCIC_OP_HALT) & runMode);
  wire autoOp = (opcode == `SCIC_OP_AUTO_FT) | (opcode == `SCIC_OP_AUTO_F) | (opcode == `SCIC_OP_AUTO_T);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign upDownSpacingSel = cfg[`SCIC_CFG_TOF2][`SCIC_SPC_HI:`SCIC_SPC_LO];
  assign launchDividerSel = divSel;
  assign continuousTimingCtl = cfg[`SCIC_CFG_CTRL][`SCIC_CTRL_CTIME];
  assign continuousIrqCtl = cfg[`SCIC_CFG_CTRL][`SCIC_CTRL_CIRQ];

  // Serial frame engine, register file and command launch in one process
  // so every register has a single writer; status and tamper sets beat clears, while busy and runMode clears beat sets
  always @(posedge sys_clk) begin
    if (!rstn) begin
      phase <= PH_DEAD;
      bitCnt <= 4'h0;
      opcode <= 8'h00;
      addr <= 8'h00;
      shIn <= 16'h0000;
      shOut <= 16'h0000;
      isRd <= 1'b0;
      dout <= 1'b0;
      busy <= 1'b0;
      runMode <= 1'b0;
      cmdStart <= 1'b0;
      cmdCode <= 4'h0;
      status <= 8'h00;
      irqN <= 1'b1;
      dpWrite <= 1'b0;
      dpAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
      for (i = 0; i < `SCIC_CFG_N; i = i + 1) begin
        cfg[i] <= `SCIC_POR_CFG;
      end
      for (i = 0; i < `SCIC_RES_N; i = i + 1) begin
        res[i] <= 16'h0000;
      end
    end else if (clkEn) begin
      cmdStart <= 1'b0;
      // Read snapshot clears only what it saw; new events still land
      status <= (status & ~stClr) | evt;
      // Registered so the pin is glitch free
      irqN <= ~(cfg[`SCIC_CFG_CTRL][`SCIC_CTRL_INTEN] & (|status));

      // Frame start resets the shifter
      if (ceFall) begin
        phase <= PH_OP;
        bitCnt <= 4'h0;
        isRd <= 1'b0;
      end

      // Output bit changes on the rising edge of a read word
      if (sckRise && phase == PH_DATA && isRd) begin
        dout <= shOut[15];
        shOut <= {shOut[14:0], 1'b0};
      end

      if (sckFall) begin
        shIn <= dataNow;
        bitCnt <= bitCnt + 4'h1;
        if (phase == PH_EXEC) begin
          phase <= PH_DEAD; // Extra clocks void the command
        end
        if (opLast) begin
          opcode <= opNow;
          addr <= opNow;
          bitCnt <= 4'h0;
          isRd <= isReadOp(opNow);
          if (isReadOp(opNow) || isWriteOp(opNow)) begin
            phase <= PH_DATA;
          end else begin
            phase <= PH_EXEC;
          end
        end
        if (rdLoad) begin
          shOut <= rdData;
        end
        if (wordLast) begin
          bitCnt <= 4'h0;
          addr <= addrInc;
          if (!isRd && isWriteOp(addr)) begin
            cfg[cfgIdx(addr | 8'h80)] <= dataNow;
          end
        end
      end

      // Execution commands after release
      if (execGo) begin
        if (launchOp || autoOp) begin
          cmdStart <= 1'b1;
          cmdCode <= opLow;
          busy <= 1'b1;
        end
        if (autoOp) begin
          runMode <= 1'b1;
        end
        if (opcode == `SCIC_OP_RESET) begin
          for (i = 0; i < `SCIC_CFG_N; i = i + 1) begin
            cfg[i] <= `SCIC_POR_CFG;
          end
          for (i = 0; i < `SCIC_RES_N; i = i + 1) begin
            res[i] <= 16'h0000;
          end
          status <= evt;
          runMode <= 1'b0;
          busy <= 1'b0;
        end
        if (opcode == `SCIC_OP_INIT) begin
          for (i = 0; i < `SCIC_INIT_N; i = i + 1) begin
            cfg[i] <= `SCIC_POR_CFG;
          end
        end
      end

      // AHB address phase; zero wait states
      dpWrite <= ahbAddrPh & hwrite;
      dpAddr <= haddr[7:0];
      if (ahbAddrPh && !hwrite) begin
        case (haddr[7:0])
          `SCIC_AHB_CMD: begin
            hrdata <= {22'h00000, runMode, busy, 4'h0, cmdCode};
          end
          `SCIC_AHB_STATUS: begin
            hrdata <= {24'h000000, status};
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end

      // Engine result words
      if (resWrite && resWrOff < `SCIC_RES_N) begin
        res[resWrOff[5:0]] <= hwdata[31:16];
      end

      // Engine completion reports
      if (done[`SCIC_ST_FLIGHT] && diffCmd) begin
        res[`SCIC_RES_DIFF] <= res[`SCIC_RES_AVGUP] - res[`SCIC_RES_AVGDN];
      end
      if (hwdata[`SCIC_DONE_FILTER] && dpWrite && dpAddr == `SCIC_AHB_DONE) begin
        cfg[`SCIC_CFG_AFE2][`SCIC_TRIM_HI:`SCIC_TRIM_LO] <= hwdata[14:8];
        busy <= runMode;
      end
      if (done[`SCIC_ST_HALT]) begin
        runMode <= 1'b0;
        busy <= 1'b0;
      end
      if ((|done[3:0]) && !runMode) begin
        busy <= 1'b0;
      end

      // Tamper latch; set beats a simultaneous write
      if (swEvent) begin
        cfg[`SCIC_CFG_CTRL][`SCIC_CTRL_CSW] <= 1'b1;
      end
    end
  end
endmodule

// Three-stage pin synchroniser with an agreement filter
module scic_sync #(
  parameter [0:0] RST_VAL = 1'b0 // Idle level of the pin
) (
  input wire sys_clk, // System clock
  input wire rstn, // Synchronous reset, low active
  input wire clkEn, // Freezes the stages when low
  input wire pinIn, // Raw pin from another domain
  output wire levelNow, // Agreed level this cycle
  output reg levelQ // Agreed level one cycle back
);
  reg [2:0] stage;

  // A change counts once stages two and three agree; a lone glitch is held off
  assign levelNow = (stage[1] == stage[2]) ? stage[2] : levelQ;

  // First stage feeds only the second, never the logic
  always @(posedge sys_clk) begin
    if (!rstn) begin
      stage <= {3{RST_VAL}};
      levelQ <= RST_VAL;
    end else if (clkEn) begin
      stage <= {stage[1:0], pinIn};
      levelQ <= levelNow;
    end
  end
endmodule

// ### scic_host.sv
`timescale 1ns/10ps
module scic_host (
  output logic ceN, // Chip enable
  output logic sck, // Link clock
  output logic din, // Data to device
  input wire dout // Data from device
);
  logic [15:0] wq [0:3];
  logic [15:0] rq [0:3];
  int gap = 300;
  initial begin
    ceN = 1'b1;
    sck = 1'b0;
    din = 1'b0;
  end
  // One frame: opcode then words, bit count set by caller
  task automatic xfer(input [7:0] op, input int nb);
    int k;
    ceN = 1'b0;
    #62.5;
    for (k = 0; k < nb; k++) begin
      sck = 1'b1;
      din = (k < 8) ? op[7 - k] : wq[((k - 8) / 16) % 4][15 - (k - 8) % 16];
      #62.5;
      sck = 1'b0;
      if (k >= 8) rq[((k - 8) / 16) % 4][15 - (k - 8) % 16] = dout;
      #62.5;
    end
    ceN = 1'b1;
    din = ~din; // No stale value between frames
    #(gap);
  endtask
endmodule

// ### scic_map.vh
`ifndef SCIC_MAP_VH
`define SCIC_MAP_VH
// Execution opcodes
`define SCIC_OP_UP 8'h00
`define SCIC_OP_DOWN 8'h01
`define SCIC_OP_DIFF 8'h02
`define SCIC_OP_TEMP 8'h03
`define SCIC_OP_RESET 8'h04
`define SCIC_OP_INIT 8'h05
`define SCIC_OP_FILTER 8'h06
`define SCIC_OP_AUTO_FT 8'h07
`define SCIC_OP_AUTO_F 8'h08
`define SCIC_OP_AUTO_T 8'h09
`define SCIC_OP_HALT 8'h0A
`define SCIC_OP_CAL 8'h0E
// Register opcode ranges
`define SCIC_RD_LO_A 8'h94
`define SCIC_RD_HI_A 8'h97
`define SCIC_RD_LO_B 8'hB0
`define SCIC_RD_HI_B 8'hC3
`define SCIC_RES_LO 8'hC4
`define SCIC_STATUS_RD 8'hFF
`define SCIC_WR_LO_A 8'h14
`define SCIC_WR_HI_A 8'h17
`define SCIC_WR_LO_B 8'h30
`define SCIC_WR_HI_B 8'h43
// Configuration array indices and fields
`define SCIC_CFG_N 24
`define SCIC_INIT_N 4
`define SCIC_CFG_AFE2 5'd3
`define SCIC_CFG_TOF1 5'd12
`define SCIC_CFG_TOF2 5'd13
`define SCIC_CFG_CTRL 5'd22
`define SCIC_TRIM_HI 14
`define SCIC_TRIM_LO 8
`define SCIC_DIV_HI 7
`define SCIC_DIV_LO 4
`define SCIC_DIV_REFUSED 4'h1
`define SCIC_SPC_HI 7
`define SCIC_SPC_LO 5
`define SCIC_CTRL_INTEN 0
`define SCIC_CTRL_CSW 1
`define SCIC_CTRL_CTIME 2
`define SCIC_CTRL_CIRQ 3
`define SCIC_POR_CFG 16'h0000
// Result array indices
`define SCIC_RES_N 59
`define SCIC_RES_AVGUP 6'd13
`define SCIC_RES_AVGDN 6'd28
`define SCIC_RES_DIFF 6'd30
// Interrupt status bits
`define SCIC_ST_FLIGHT 0
`define SCIC_ST_TEMP 1
`define SCIC_ST_HALT 2
`define SCIC_ST_CAL 3
`define SCIC_ST_CSW 4
`define SCIC_ST_TMO 5
// AHB offsets
`define SCIC_AHB_CMD 8'h00
`define SCIC_AHB_DONE 8'h04
`define SCIC_AHB_RESULT 8'h08
`define SCIC_AHB_STATUS 8'h0C
`define SCIC_DONE_FILTER 4
`define SCIC_BIT_BUSY 8
`define SCIC_BIT_RUN 9
`endif

// ### scic_props.sv
`timescale 1ns/10ps
module scic_props (
  input wire sys_clk, // Clock
  input wire rstn, // Reset, low active
  input wire hsel, // Select
  input wire [31:0] haddr, // Address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write
  input wire hready, // Bus ready
  input wire [31:0] hrdata, // Read data
  input wire hreadyout, // Slave ready
  input wire hresp, // Response
  input wire ceN, // Chip enable
  input wire sck, // Link clock
  input wire dout, // Serial out
  input wire irqN, // Interrupt
  input wire cmdStart, // Launch pulse
  input wire [3:0] cmdCode // Launch code
);
  logic sckQ;
  logic [6:0] sinceRise;
  logic [6:0] sinceCe;
  // Saturating ages of last sck rise and last low ceN
  always @(posedge sys_clk) begin
    sckQ <= sck;
    if (!rstn) begin
      sinceRise <= 7'h7F;
      sinceCe <= 7'h7F;
    end else begin
      sinceRise <= (sck && !sckQ) ? 7'h00 : sinceRise + {6'h00, sinceRise != 7'h7F};
      sinceCe <= !ceN ? 7'h00 : sinceCe + {6'h00, sinceCe != 7'h7F};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Read address phase at a given offset
  sequence s_rd(a);
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
  endsequence
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus wait or error seen");
  property p_reset; disable iff (1'b0) !rstn |=> irqN && !cmdStart && !dout && hrdata == 32'h0 && cmdCode == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_pulse; cmdStart |=> !cmdStart; endproperty
  a_pulse: assert property (p_pulse) else $error("launch pulse too long");
  property p_code; $changed(cmdCode) |-> cmdStart; endproperty
  a_code: assert property (p_code) else $error("code moved without launch");
  property p_exec; cmdStart |-> ceN && $past(ceN) && $past(ceN, 2); endproperty
  a_exec: assert property (p_exec) else $error("launch while selected");
  property p_dout; $changed(dout) |-> sinceRise <= 7'd8; endproperty
  a_dout: assert property (p_dout) else $error("serial out moved off rise");
  property p_irq; $rose(irqN) |-> sinceCe <= 7'd20; endproperty
  a_irq: assert property (p_irq) else $error("interrupt released without access");
  property p_rdcmd; s_rd(8'h00) |=> hrdata[3:0] == $past(cmdCode); endproperty
  a_rdcmd: assert property (p_rdcmd) else $error("command code read wrong");
  property p_unmap; s_rd(8'h10) |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
`include "scic_map.vh"
module tb_top;
  logic sys_clk, rstn, clkEn, hsel, hwrite, hreadyout, hresp, ceN, sck, din, dout, caseSwitchIn, irqN, cmdStart;
  logic continuousTimingCtl, continuousIrqCtl;
  logic [31:0] haddr, hwdata, hrdata, r, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize, upDownSpacingSel;
  logic [3:0] cmdCode, launchDividerSel;
  logic [15:0] sv;
  logic [7:0] ops [0:6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0E, 8'h07, 8'h08};
  int n_mismatch = 0;
  int n_tests = 0;
  int nStart = 0;
  int s;
  int seed = 32'h99A57C7C;
  scic_ctrl uut (.sys_clk, .rstn, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .ceN, .sck, .din, .dout, .caseSwitchIn, .irqN, .cmdStart, .cmdCode,
    .upDownSpacingSel, .launchDividerSel, .continuousTimingCtl, .continuousIrqCtl);
  scic_host host (.ceN, .sck, .din, .dout);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Launch pulses counted for the exec checks
  always @(posedge sys_clk) if (cmdStart === 1'b1) nStart <= nStart + 1;
  task conclude;
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function [15:0] fld(input [15:0] v, input int hi, input int lo);
    fld = (v >> lo) & ((16'h0001 << (hi - lo + 1)) - 16'h0001);
  endfunction
  // Single word transfer, waits on the slave's ready
  task ahb(input w, input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task rd(input [7:0] o); host.xfer(o, 24); sv = host.rq[0]; endtask
  task wr(input [7:0] o, input [15:0] v); host.wq[0] = v; host.xfer(o, 24); endtask
  task ex(input [7:0] o, input int nb, input int n); s = nStart; host.xfer(o, nb); chk(nStart - s, n); endtask
  initial begin
    #500000;
    n_mismatch++;
    conclude;
  end
  initial begin
    rstn = 1'b0; clkEn = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; caseSwitchIn = 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    ahb(1'b0, `SCIC_AHB_CMD, 32'h0); chk(r, 32'h0);
    ahb(1'b0, 8'h10, 32'h0); chk(r, 32'h0);
    // Burst write and read back, then initialise restores only 14h-17h
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin rnd = $random(seed); host.wq[i] = rnd[15:0]; end
      host.gap = 300 + 200 * j;
      host.xfer(j ? `SCIC_WR_LO_B : `SCIC_WR_LO_A, 72);
      host.xfer(j ? `SCIC_RD_LO_B : `SCIC_RD_LO_A, 72);
      for (int i = 0; i < 4; i++) chk(host.rq[i], host.wq[i]);
    end
    host.xfer(`SCIC_OP_INIT, 8);
    host.xfer(`SCIC_RD_LO_A, 40);
    chk(host.rq[0], 16'h0);
    chk(host.rq[1], 16'h0);
    host.xfer(`SCIC_RD_LO_B, 40);
    chk(host.rq[0], host.wq[0]);
    chk(host.rq[1], host.wq[1]);
    rnd = $random(seed);
    host.wq[0] = {rnd[15:8], rnd[7:4] | 4'h2, rnd[3:0]};
    host.wq[1] = rnd[31:16];
    host.xfer(8'h38, 40);
    chk(launchDividerSel, fld(host.wq[0], 7, 4));
    chk(upDownSpacingSel, fld(host.wq[1], 7, 5));
    ex(`SCIC_OP_FILTER, 8, 1);
    ahb(1'b1, `SCIC_AHB_DONE, 32'h00005510);
    rd(8'h97); chk(fld(sv, 14, 8), 16'h0055);
    wr(8'h38, 16'h0010);
    ex(`SCIC_OP_FILTER, 8, 0);
    ex(`SCIC_OP_HALT, 8, 0);
    ex(`SCIC_OP_UP, 9, 0);
    ex(8'h0B, 8, 0);
    for (int i = 0; i < 7; i++) begin
      ex(ops[i], 8, 1); chk(cmdCode, ops[i][3:0]);
      if (i > 4) begin
        ex(`SCIC_OP_HALT, 8, 1);
        ahb(1'b1, `SCIC_AHB_DONE, 32'h4);
      end
    end
    ex(`SCIC_OP_AUTO_T, 8, 1); ex(`SCIC_OP_HALT, 8, 1);
    ahb(1'b1, `SCIC_AHB_DONE, 32'h4);
    ahb(1'b0, `SCIC_AHB_STATUS, 32'h0); chk(r & 32'h4, 32'h4);
    rd(`SCIC_STATUS_RD);
    wr(8'h42, 16'h000D);
    chk(continuousTimingCtl, 1'b1);
    chk(continuousIrqCtl, 1'b1);
    ahb(1'b1, `SCIC_AHB_DONE, 32'h1);
    repeat (5) @(posedge sys_clk);
    chk(irqN, 1'b0);
    rd(`SCIC_STATUS_RD); chk(sv, 16'h0001); chk(irqN, 1'b1);
    rd(`SCIC_STATUS_RD); chk(sv, 16'h0000);
    wr(8'h42, 16'h0000);
    ahb(1'b1, `SCIC_AHB_DONE, 32'h2);
    repeat (5) @(posedge sys_clk);
    chk(irqN, 1'b1);
    rd(`SCIC_STATUS_RD); chk(sv, 16'h0002);
    wr(8'h42, 16'h0001);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    caseSwitchIn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(irqN, 1'b1);
    clkEn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(irqN, 1'b0);
    rd(8'hC2); chk(sv, 16'h0003);
    rd(`SCIC_STATUS_RD); chk(sv, 16'h0010);
    @(posedge sys_clk);
    caseSwitchIn <= 1'b0;
    fork
      rd(`SCIC_STATUS_RD);
      begin #1200; @(posedge sys_clk); ahb(1'b1, `SCIC_AHB_DONE, 32'h8); end
    join
    rnd = {16'h0, sv};
    rd(`SCIC_STATUS_RD); chk((rnd | sv) & 32'h8, 32'h8);
    ahb(1'b1, `SCIC_AHB_DONE, 32'h1);
    host.xfer(`SCIC_OP_RESET, 8);
    rd(`SCIC_STATUS_RD); chk(sv, 16'h0);
    rd(8'hB8); chk(sv, 16'h0); chk(launchDividerSel, 4'h0);
    rd(8'hC2);
    chk(sv, 16'h0);
    chk(irqN, 1'b1);
    conclude;
  end
endmodule
bind scic_ctrl scic_props chk (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .ceN, .sck, .dout, .irqN, .cmdStart, .cmdCode);
